// [pkg/tdc_ctrl_pkg.sv]
// Constants and carrier types for the two-channel time converter control.
// Assumes a 25 MHz system clock and an 8-bit host register port.
package tdc_ctrl_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int READY_NS = 30;
  localparam int READY_CYC = (READY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int POR_HOLD_NS = 50;
  localparam int POR_CYC = (POR_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CAL_NS = 4200;
  localparam int CAL_CYC = (CAL_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int RAW_NS = 180;
  localparam int RAW_CYC = (RAW_NS * (CLK_HZ / 1_000_000)) / 1000;
  // Dead times, given in ns (each below one 40 ns cycle); derived cycle counts clamped to one
  localparam int START_DEAD_NS = 3;
  localparam int RETRIG_DEAD_NS = 6;
  localparam int RECOVERY_NS = 15;
  localparam int DEAD_CYC = (RETRIG_DEAD_NS * (CLK_HZ / 1_000_000)) / 1000 < 1
                            ? 1 : (RETRIG_DEAD_NS*(CLK_HZ/1_000_000))/1000;
  localparam int REC_CYC = (RECOVERY_NS * (CLK_HZ / 1_000_000)) / 1000 < 1
                           ? 1 : (RECOVERY_NS*(CLK_HZ/1_000_000))/1000;
  localparam logic [15:0] EVENT_LIMIT = 16'h7800;

  // Register addresses
  localparam logic [3:0] ADDR_CTRL0  = 4'h0;
  localparam logic [3:0] ADDR_CTRL2  = 4'h2;
  localparam logic [3:0] ADDR_CTRL6  = 4'h6;
  localparam logic [3:0] ADDR_CTRL7  = 4'h7;
  localparam logic [3:0] ADDR_RES    = 4'h0;
  localparam logic [3:0] ADDR_STAT1  = 4'h8;
  localparam logic [3:0] ADDR_STAT2  = 4'h9;
  localparam logic [3:0] ADDR_INIT   = 4'hB;

  // Field positions
  localparam int CTRL0_RANGE = 4;
  localparam int CTRL0_MULT  = 5;
  localparam int CTRL0_CAL   = 6;
  localparam int CTRL6_NOISE = 4;
  localparam int CTRL6_RETRIG = 5;
  localparam int CTRL6_QUEUE = 6;
  localparam int INIT_TDC_BIT = 0;
  localparam int INIT_ALU_BIT = 1;
  localparam int INIT_NOISE_BIT = 2;
  localparam logic [3:0] POR_PATTERN = 4'hA;

  // Reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] CTRL6_RST = 8'h00;
  localparam logic [7:0] CTRL7_RST = 8'h24;
  localparam logic [6:0] NOISE_SEED = 7'h01;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  typedef struct packed {
    logic       start;
    logic [1:0] stop;
  } hit_in_s;
endpackage

// [verification/tb_tdc_ctrl.sv]
// Self-checking bench for tdc_ctrl: host port, hit inputs and status.
// Assumes the host model owns the bus; hits and time base are driven here.
`timescale 1ns/1ns
module tb_tdc_ctrl;
  import tdc_ctrl_pkg::*;
  logic        clk;
  logic        rst_n;
  bus_req_s    bus;
  hit_in_s     hits;
  hit_in_s     pol;
  logic [15:0] tick;
  logic [7:0]  rdata;
  logic        busy;
  logic        ready;
  logic [13:0] ofs;
  logic [13:0] ofs0;
  logic        range2;
  logic [7:0]  d;
  logic [7:0]  lo;
  int          num_errors;
  int          num_checks;
  tdc_host_model u_host (.i_clk(clk), .o_bus(bus), .i_rdata(rdata));
  tdc_ctrl u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_BUS(bus),
    .O_RDATA(rdata), .I_HITS(hits), .I_TIME(tick), .O_ALU_BUSY(busy),
    .O_READY(ready), .O_NOISE_OFS(ofs), .O_RANGE2(range2));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
    tick <= tick + 16'h0001;
  task automatic chk(input string n, input logic [15:0] g, e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Pulses three cycles apart, well inside the event window
  task automatic pulse(input hit_in_s m, input int n);
    repeat (n)
    begin
      @(posedge clk);
      hits <= hit_in_s'(m ^ pol);
      @(posedge clk);
      hits <= pol;
      @(posedge clk);
    end
  endtask
  task automatic meas(input int n1, n2, input logic [5:0] e, input string n);
    u_host.wr(ADDR_INIT, 8'h01);
    pulse(3'b100, 1);
    pulse(3'b001, n1);
    pulse(3'b010, n2);
    u_host.rd(ADDR_STAT1, d);
    chk(n, 16'(d[5:0]), 16'(e));
  endtask
  task automatic wait_idle();
    int i;
    repeat (2) @(posedge clk);
    for (i = 0; i < 300 && busy !== 1'b0; i++)
      @(posedge clk);
    if (busy !== 1'b0)
    begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic rd_res(input string n, input logic [15:0] e);
    u_host.rd(ADDR_RES, lo);
    u_host.rd(ADDR_RES, d);
    chk(n, {d, lo}, e);
  endtask
  // Starts at 0 and 3, stop at 6, late start at 9, stop at 12
  task automatic retrig();
    u_host.wr(ADDR_CTRL6, 8'h20);
    u_host.wr(ADDR_INIT, 8'h03);
    pulse(3'b100, 2);
    pulse(3'b001, 1);
    pulse(3'b100, 1);
    pulse(3'b001, 1);
    u_host.wr(ADDR_CTRL2, 8'h01);
    wait_idle();
    rd_res("retrig last", 16'h0003);
    u_host.wr(ADDR_INIT, 8'h02);
    u_host.wr(ADDR_CTRL2, 8'h02);
    wait_idle();
    rd_res("retrig late", 16'h0009);
  endtask
  // Stop beside its start, then a stop held over two cycles
  task automatic early_rec();
    u_host.wr(ADDR_CTRL6, 8'h00);
    u_host.wr(ADDR_INIT, 8'h01);
    pulse(3'b101, 1);
    pulse(3'b001, 1);
    u_host.rd(ADDR_STAT1, d);
    chk("early stop", 16'(d[5:0]), 16'h0001);
    u_host.wr(ADDR_INIT, 8'h01);
    pulse(3'b100, 1);
    @(posedge clk);
    hits <= 3'b001;
    repeat (2) @(posedge clk);
    hits <= pol;
    u_host.rd(ADDR_STAT1, d);
    chk("recovery", 16'(d[5:0]), 16'h0001);
  endtask
  initial
  begin
    rst_n = 1'b0;
    hits = '0;
    pol = '0;
    tick = '0;
    num_errors = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("range dflt", 16'(range2), 16'h0);
    meas(5, 5, 6'h24, "dflt hits");
    u_host.wr(ADDR_CTRL7, 8'h0A);
    meas(3, 3, 6'h0A, "hit limit");
    u_host.wr(ADDR_CTRL7, 8'h00);
    meas(2, 2, 6'h00, "both off");
    u_host.wr(ADDR_CTRL7, CTRL7_RST);
    pol = 3'b111;
    @(posedge clk);
    hits <= pol;
    u_host.wr(ADDR_CTRL0, 8'h07);
    meas(2, 1, 6'h0A, "falling");
    pol = '0;
    u_host.wr(ADDR_CTRL0, 8'h00);
    hits <= pol;
    u_host.wr(ADDR_CTRL6, 8'h40);
    meas(6, 1, 6'h14, "queue");
    u_host.wr(ADDR_CTRL6, 8'h00);
    meas(2, 0, 6'h02, "two hits");
    u_host.wr(ADDR_CTRL2, 8'h21);
    wait_idle();
    rd_res("raw diff", 16'hFFFD);
    u_host.rd(ADDR_STAT2, d);
    chk("ptr one", 16'(d[2:0]), 16'h1);
    u_host.wr(ADDR_INIT, 8'h02);
    u_host.rd(ADDR_STAT2, d);
    chk("ptr init", 16'(d[2:0]), 16'h0);
    u_host.wr(ADDR_CTRL0, 8'h10);
    @(negedge clk);
    chk("range two", 16'(range2), 16'h1);
    u_host.por();
    chk("range por", 16'(range2), 16'h0);
    u_host.wr(ADDR_INIT, 8'h02);
    rd_res("kept", 16'hFFFD);
    u_host.wr(ADDR_CTRL0, 8'h40);
    u_host.wr(ADDR_CTRL2, 8'h01);
    wait_idle();
    u_host.wr(ADDR_CTRL0, 8'h00);
    u_host.wr(ADDR_CTRL6, 8'h10);
    @(negedge clk);
    ofs0 = ofs;
    chk("noise on", 16'(ofs != '0), 16'h1);
    repeat (4) @(negedge clk);
    chk("noise hold", 16'(ofs), 16'(ofs0));
    u_host.wr(ADDR_INIT, 8'h04);
    @(negedge clk);
    chk("noise step", 16'(ofs != ofs0), 16'h1);
    ofs0 = ofs;
    u_host.wr(ADDR_CTRL6, 8'h00);
    u_host.wr(ADDR_INIT, 8'h04);
    @(negedge clk);
    chk("noise off", 16'(ofs), 16'h0);
    u_host.wr(ADDR_CTRL6, 8'h10);
    @(negedge clk);
    chk("noise idle step", 16'(ofs != ofs0), 16'h1);
    retrig();
    early_rec();
    give_verdict();
  end
endmodule

// [verification/tdc_ctrl_asserts.sv]
// Port-level assertions for tdc_ctrl, bound into the design.
// Assumes one clock domain and a host that keeps the bus rules.
`timescale 1ns/1ns
module tdc_ctrl_asserts
  import tdc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic                   I_CLK,
  input wire logic                   I_RST_N,
  // Host port and hits
  input wire tdc_ctrl_pkg::bus_req_s I_BUS,
  input wire logic [7:0]             O_RDATA,
  input wire tdc_ctrl_pkg::hit_in_s  I_HITS,
  input wire logic [15:0]            I_TIME,
  // Status
  input wire logic                   O_ALU_BUSY,
  input wire logic                   O_READY,
  input wire logic [13:0]            O_NOISE_OFS,
  input wire logic                   O_RANGE2
);
  logic       wr_ok;
  logic       por_cmd;
  logic       noise_q;
  logic       cal_q;
  logic [7:0] busy_q;
  assign wr_ok = I_BUS.wr && O_READY;
  assign por_cmd = wr_ok && I_BUS.addr == ADDR_INIT
                   && I_BUS.wdata[7:4] == POR_PATTERN;
  // Shadow of the control bits the properties depend on
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N || por_cmd)
    begin
      noise_q <= 1'b0;
      cal_q <= 1'b0;
    end
    else if (wr_ok && I_BUS.addr == ADDR_CTRL6)
      noise_q <= I_BUS.wdata[CTRL6_NOISE];
    else if (wr_ok && I_BUS.addr == ADDR_CTRL0)
      cal_q <= I_BUS.wdata[CTRL0_CAL];
  end
  always_ff @(posedge I_CLK)
    busy_q <= (I_RST_N && O_ALU_BUSY) ? busy_q + 8'h01 : 8'h00;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  sequence alu_go;
    wr_ok && I_BUS.addr == ADDR_CTRL2;
  endsequence
  sequence back_ready;
    ##[1:8] O_READY;
  endsequence
  range_sel_a:
    assert property (wr_ok && I_BUS.addr == ADDR_CTRL0 |=>
      O_RANGE2 == $past(I_BUS.wdata[CTRL0_RANGE])) else $error("range bit");
  soft_reset_a:
    assert property (por_cmd |=> !O_READY && !O_RANGE2 ##0 back_ready)
      else $error("soft reset");
  hw_reset_a:
    assert property ($rose(I_RST_N) |-> !O_RANGE2 ##0 back_ready)
      else $error("pin reset");
  noise_off_a:
    assert property (!noise_q |-> O_NOISE_OFS == '0) else $error("noise off");
  noise_hold_a:
    assert property (noise_q && $past(noise_q) && !$past(I_BUS.wr)
      |-> $stable(O_NOISE_OFS)) else $error("noise moved");
  noise_step_a:
    assert property (noise_q && wr_ok && I_BUS.addr == ADDR_INIT && !por_cmd
      && I_BUS.wdata[INIT_NOISE_BIT] |=> $changed(O_NOISE_OFS))
      else $error("noise step");
  alu_start_a:
    assert property (alu_go |-> ##[1:2] O_ALU_BUSY) else $error("alu start");
  alu_raw_a:
    assert property ($fell(O_ALU_BUSY) && !cal_q |-> busy_q inside {[3:6]})
      else $error("raw alu time");
  alu_cal_a:
    assert property ($fell(O_ALU_BUSY) && cal_q
      |-> busy_q inside {[100:110]}) else $error("cal alu time");
  alu_init_a:
    assert property (wr_ok && I_BUS.addr == ADDR_INIT && !por_cmd
      && I_BUS.wdata[INIT_ALU_BIT] |-> ##[1:2] O_READY)
      else $error("alu init ready");
endmodule
bind tdc_ctrl tdc_ctrl_asserts u_asserts (.I_CLK, .I_RST_N, .I_BUS,
  .O_RDATA, .I_HITS, .I_TIME, .O_ALU_BUSY, .O_READY, .O_NOISE_OFS, .O_RANGE2);

// [verification/tdc_host_model.sv]
// Host processor model for the 8-bit register port.
// Assumes the block never stalls and read data follow the strobe by a cycle.
`timescale 1ns/1ns
module tdc_host_model
  import tdc_ctrl_pkg::*;
(
  // Clock
  input  wire logic                   i_clk,
  // Register port
  output tdc_ctrl_pkg::bus_req_s      o_bus,
  input  wire logic [7:0]             i_rdata
);
  initial o_bus = '0;
  // Address held after a strobe so repeated reads stay on one result
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk);
    o_bus <= '{a, ~d, 1'b0, 1'b0};
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_clk);
    o_bus <= '{a, 8'hFF, 1'b0, 1'b0};
    #1 d = i_rdata;
  endtask
  // Block ignores commands while it resets itself
  task automatic por();
    wr(ADDR_INIT, {POR_PATTERN, 4'h0});
    repeat (POR_CYC + 2) @(posedge i_clk);
  endtask
endmodule

// [verilog/tdc_ctrl.sv]
// Control logic of a two-channel time converter: init commands, range one
// measurement sequencing, hit bookkeeping and subtraction unit timing.
// Assumes start/stop inputs already synchronous to I_CLK, one cycle pulses
// of the host port, and a fine time counter supplied as I_TIME.
//
// Behaviour
// - ALU init rewinds result pointer, ready after
// - Noise clock bit steps pseudo-random counter
// - Upper nibble A resets whole chip; here the read port byte flag and pointer are cleared only by I_RST_N
// - Raw and result registers survive every reset
// - Control 0 bit 4 selects range
// - Common start, four stops per channel stored
// - Stops under 3ns after start ignored
// - Same-channel events within 15ns lost
// - Control 2 nibbles: lower minus upper
// - Calibrated 32 bit slow, raw 16 fast
// - Three-bit hit limit per channel
// - Both limits zero disables starts
// - Control 0 bits 2-0 pick edges
// - Retrigger restarts until first stop
// - Retrigger dead time becomes 6ns
// - Queuing routes stop one into channel two
// - Auto noise offsets each stop input
// - Offset changes only when clocked
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module tdc_ctrl
  import tdc_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                 I_CLK,
  input  wire logic                 I_RST_N,
  // Host register port
  input  wire tdc_ctrl_pkg::bus_req_s I_BUS,
  output logic [7:0]                O_RDATA,
  // Measurement inputs and fine time base
  input  wire tdc_ctrl_pkg::hit_in_s I_HITS,
  input  wire logic [15:0]          I_TIME,
  // Status
  output logic                      O_ALU_BUSY,
  output logic                      O_READY,
  output logic [13:0]               O_NOISE_OFS,
  output logic                      O_RANGE2
);
  import tdc_ctrl_pkg::*;

  typedef enum logic [1:0] {IDLE, ARMED, RUNNING} meas_e;
  typedef enum logic [1:0] {A_IDLE, A_CALC, A_WRITE} alu_e;

  logic [7:0]  ctrl0_q, ctrl2_q, ctrl6_q, ctrl7_q;
  logic        por_q;
  logic [7:0]  por_cnt_q;
  logic [7:0]  rdy_cnt_q;
  logic        soft_rst;
  logic        init_wr;
  logic        ign_cmd;
  logic [6:0]  lfsr_q;
  meas_e       meas_q;
  alu_e        alu_q;
  logic [7:0]  alu_cnt_q;
  logic [2:0]  ptr_q;
  logic        byte_q;
  logic [2:0]  hits_q [2];
  logic [15:0] raw_q [2][4];
  logic [15:0] res_q [8];
  logic [15:0] t0_q;
  logic [2:0]  ch_rec_q [2];
  logic        first_stop_q;
  logic        ofl_q;
  logic [2:0]  prev_q;
  logic        start_ev;
  logic [1:0]  stop_ev;
  logic [1:0]  stop_acc;
  logic        unit_off;
  logic        rst_all;
  logic [15:0] ev_a, ev_b, diff;
  logic [15:0] rel_t;
  logic        in_dead;

  // Software reset only takes effect while the port is listening
  assign ign_cmd  = por_q;
  assign init_wr  = I_BUS.wr && I_BUS.addr == ADDR_INIT && !ign_cmd;
  assign soft_rst = init_wr && I_BUS.wdata[7:4] == POR_PATTERN;
  assign rst_all  = !I_RST_N || soft_rst;

  // Software reset hold time
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      por_q     <= 1'b0;
      por_cnt_q <= 8'h00;
    end
    else if (soft_rst)
    begin
      por_q     <= 1'b1;
      por_cnt_q <= 8'(POR_CYC);
    end
    else if (por_cnt_q != 8'h00)
      por_cnt_q <= por_cnt_q - 8'h01;
    else
      por_q <= 1'b0;
  end

  // Control registers, defaults restored by either reset
  always_ff @(posedge I_CLK)
  begin
    if (rst_all)
    begin
      ctrl0_q <= CTRL0_RST;
      ctrl2_q <= CTRL2_RST;
      ctrl6_q <= CTRL6_RST;
      ctrl7_q <= CTRL7_RST;
    end
    else if (I_BUS.wr && !ign_cmd)
    begin
      if (I_BUS.addr == ADDR_CTRL0)
        ctrl0_q <= I_BUS.wdata;
      else if (I_BUS.addr == ADDR_CTRL2)
        ctrl2_q <= I_BUS.wdata;
      else if (I_BUS.addr == ADDR_CTRL6)
        ctrl6_q <= I_BUS.wdata;
      else if (I_BUS.addr == ADDR_CTRL7)
        ctrl7_q <= I_BUS.wdata;
    end
  end

  assign O_RANGE2 = ctrl0_q[CTRL0_RANGE];

  // Noise generator: advances only on the init bit
  always_ff @(posedge I_CLK)
  begin
    if (rst_all)
      lfsr_q <= NOISE_SEED;
    else if (init_wr && I_BUS.wdata[INIT_NOISE_BIT])
      lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
  end

  // Offsets per stop input, the second a rotation of the first, zero when noise is off
  assign O_NOISE_OFS = ctrl6_q[CTRL6_NOISE]
                       ? {lfsr_q, {lfsr_q[2:0], lfsr_q[6:3]}}
                       : 14'h0000;

  // Edge selection: data already conditioned to polarity per bit
  assign start_ev = I_HITS.start ^ ctrl0_q[0];
  assign unit_off = ctrl7_q[2:0] == 3'b000 && ctrl7_q[5:3] == 3'b000;
  assign rel_t    = I_TIME - t0_q;
  // Sub-cycle dead times collapse onto the one cycle after the start cycle
  assign in_dead  = meas_q == ARMED;

  always_comb
  begin
    stop_ev[0] = I_HITS.stop[0] ^ ctrl0_q[1];
    stop_ev[1] = (I_HITS.stop[1] ^ ctrl0_q[2]) && !ctrl6_q[CTRL6_QUEUE];
  end

  // Per-channel acceptance
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_ch
      always_comb
      begin
        stop_acc[g] = meas_q == RUNNING && stop_ev[g]
                      && ch_rec_q[g] == 3'h0
                      && hits_q[g] < ctrl7_q[3*g +: 3];
        if (g == 1 && ctrl6_q[CTRL6_QUEUE] && !O_RANGE2)
          stop_acc[g] = meas_q == RUNNING && stop_ev[0]
                        && ch_rec_q[0] == 3'h0
                        && hits_q[0] >= ctrl7_q[2:0]
                        && hits_q[1] < ctrl7_q[5:3];
        if (g == 0 && ctrl6_q[CTRL6_QUEUE] && hits_q[0] >= ctrl7_q[2:0])
          stop_acc[g] = 1'b0;
      end

      always_ff @(posedge I_CLK)
      begin
        if (rst_all || (init_wr && I_BUS.wdata[INIT_TDC_BIT]))
          ch_rec_q[g] <= 3'h0;
        else if (stop_acc[g] || (g == 1 && stop_acc[0] && ctrl6_q[CTRL6_QUEUE]))
          ch_rec_q[g] <= 3'(REC_CYC);
        else if (ch_rec_q[g] != 3'h0)
          ch_rec_q[g] <= ch_rec_q[g] - 3'h1;
      end

      // Raw values are never reset
      always_ff @(posedge I_CLK)
      begin
        if (stop_acc[g])
          raw_q[g][hits_q[g][1:0]] <= rel_t;
      end
    end
  endgenerate

  // Measurement sequencing
  always_ff @(posedge I_CLK)
  begin
    if (rst_all || (init_wr && I_BUS.wdata[INIT_TDC_BIT]))
    begin
      meas_q       <= IDLE;
      hits_q[0]    <= 3'h0;
      hits_q[1]    <= 3'h0;
      first_stop_q <= 1'b0;
      ofl_q        <= 1'b0;
      t0_q         <= 16'h0000;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
        if (stop_acc[c])
          hits_q[c] <= hits_q[c] + 3'h1;
      if (stop_acc != 2'b00)
        first_stop_q <= 1'b1;
      if (start_ev && !unit_off && !O_RANGE2 && (meas_q == IDLE
          || (ctrl6_q[CTRL6_RETRIG] && !first_stop_q
              && stop_acc == 2'b00)))
      begin
        meas_q <= ARMED;
        t0_q   <= I_TIME;
      end
      else if (in_dead)
        meas_q <= RUNNING;
      else if (meas_q == RUNNING && rel_t >= EVENT_LIMIT)
        ofl_q <= 1'b1;
    end
  end

  // Subtraction operands selected by nibble: 0 start, 1-4 ch1, 9-C ch2
  function automatic logic [15:0] pick(input logic [3:0] sel);
    if (sel == 4'h0)
      pick = 16'h0000;
    else if (sel[3])
      pick = raw_q[1][sel[1:0] - 2'h1];
    else
      pick = raw_q[0][sel[1:0] - 2'h1];
  endfunction

  assign ev_a = pick(ctrl2_q[3:0]);
  assign ev_b = pick(ctrl2_q[7:4]);
  assign diff = ev_a - ev_b;

  // Arithmetic unit: a new result on each ALU init is not modelled;
  // a write to control 2 launches one calculation
  always_ff @(posedge I_CLK)
  begin
    if (rst_all)
    begin
      alu_q     <= A_IDLE;
      alu_cnt_q <= 8'h00;
      ptr_q     <= 3'h0;
    end
    else if (init_wr && I_BUS.wdata[INIT_ALU_BIT])
    begin
      alu_q <= A_IDLE;
      ptr_q <= 3'h0;
    end
    else
    begin
      case (alu_q)
        A_IDLE:
          if (I_BUS.wr && I_BUS.addr == ADDR_CTRL2 && !ign_cmd)
          begin
            alu_q     <= A_CALC;
            alu_cnt_q <= ctrl0_q[CTRL0_CAL] ? 8'(CAL_CYC)
                                            : 8'(RAW_CYC);
          end
        A_CALC:
          if (alu_cnt_q == 8'h01)
            alu_q <= A_WRITE;
          else
            alu_cnt_q <= alu_cnt_q - 8'h01;
        A_WRITE:
        begin
          alu_q <= A_IDLE;
          ptr_q <= ptr_q + (ctrl0_q[CTRL0_CAL] ? 3'h2 : 3'h1);
        end
        default:
          alu_q <= A_IDLE;
      endcase
    end
  end

  // Result registers are never reset
  always_ff @(posedge I_CLK)
  begin
    if (alu_q == A_WRITE)
    begin
      res_q[ptr_q] <= diff;
      if (ctrl0_q[CTRL0_CAL])
        res_q[ptr_q + 3'h1] <= {15'h0000, diff[15]};
    end
  end

  assign O_ALU_BUSY = alu_q != A_IDLE;

  // Ready delay after ALU or unit init
  always_ff @(posedge I_CLK)
  begin
    if (rst_all)
      rdy_cnt_q <= 8'(POR_CYC);
    else if (init_wr && (I_BUS.wdata[INIT_ALU_BIT] || I_BUS.wdata[INIT_TDC_BIT]))
      rdy_cnt_q <= 8'(READY_CYC);
    else if (rdy_cnt_q != 8'h00)
      rdy_cnt_q <= rdy_cnt_q - 8'h01;
  end

  assign O_READY = rdy_cnt_q == 8'h00 && !por_q;

  // Read port: result words read low byte then high, pointer auto-steps
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      O_RDATA <= 8'h00;
      byte_q  <= 1'b0;
      prev_q  <= 3'h0;
    end
    else if (I_BUS.rd)
    begin
      if (I_BUS.addr == ADDR_STAT1)
        O_RDATA <= {1'b0, ofl_q, hits_q[1], hits_q[0]};
      else if (I_BUS.addr == ADDR_STAT2)
        O_RDATA <= {3'h0, ctrl0_q[CTRL0_MULT], ctrl0_q[CTRL0_CAL], ptr_q};
      else if (I_BUS.addr < 4'h8)
      begin
        if (byte_q && I_BUS.addr[2:0] == prev_q)
        begin
          O_RDATA <= res_q[prev_q][15:8];
          byte_q  <= 1'b0;
          prev_q  <= prev_q + 3'h1;
        end
        else
        begin
          O_RDATA <= res_q[I_BUS.addr[2:0]][7:0];
          byte_q  <= 1'b1;
          prev_q  <= I_BUS.addr[2:0];
        end
      end
      else
        O_RDATA <= 8'h00;
    end
  end
endmodule
